// ===== core/bcc_bridge_cmd.sv
// Behaviour
// - io space enable clear: no claim of primary io window accesses.
// - memory space enable clear: no claim of memory or prefetch window accesses.
// - forward enable clear: no upstream memory, io or msi requests from below.
// - forward enable clear: non-posted memory, io or msi requests from below get unsupported request.
// - forward enable never blocks completions or other request kinds.
// - parity response set: poisoned completion or write sets parity flag.
// - parity response clear: parity flag is never set.
// - own errors reported when system error enable or device control enables set.
// - nonfatal and fatal messages forwarded upstream only with system error enable.
// - correctable error messages always forwarded upstream.
// - legacy interrupt disable clear negates own interrupt, as printed.
// - legacy interrupt disable has no effect on forwarded interrupts.
// - bits 3, 4 and 5 read-only zero.
// - bits 7, 9 and 15:11 read-only zero.
// - sending fatal or nonfatal message with system error enable sets status bit 14.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module bcc_bridge_cmd
  import bcc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // primary side window hits
  input  wire logic        prim_io_hit,
  input  wire logic        prim_mem_hit,
  input  wire logic        prim_pref_hit,
  output logic             io_claim,
  output logic             mem_claim,
  // requests from the secondary side
  input  wire logic        up_req_valid,
  input  wire bcc_kind_e   up_req_kind,
  input  wire logic        up_req_nonposted,
  output logic             up_req_fwd,
  output logic             up_req_ur,
  // poisoned data events
  input  wire logic        poisoned_cpl_rx,
  input  wire logic        poisoned_wr_gen,
  // own error detection and device control enables
  input  wire logic        own_err_nonfatal,
  input  wire logic        own_err_fatal,
  input  wire logic        devctl_nonfatal_en,
  input  wire logic        devctl_fatal_en,
  output logic             own_nonfatal_msg,
  output logic             own_fatal_msg,
  // error messages from the secondary side
  input  wire logic        sec_err_cor,
  input  wire logic        sec_err_nonfatal,
  input  wire logic        sec_err_fatal,
  output logic             fwd_err_cor,
  output logic             fwd_err_nonfatal,
  output logic             fwd_err_fatal,
  // legacy interrupts
  input  wire logic        own_int_req,
  input  wire logic        sec_int_req,
  output logic             own_int_out,
  output logic             sec_int_out,
  output logic             irq
);

  typedef struct packed
  {
    logic [15:0] cmd;
    logic [2:0]  irq_mask;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        own_nf;
    logic        own_fatal;
    logic        fwd_cor;
    logic        fwd_nf;
    logic        fwd_fatal;
    logic        own_int;
    logic        sec_int;
    logic        irq;
  } bcc_top_s;

  bcc_top_s st_ff;
  bcc_top_s nxt_st;

  logic              setup_phase;
  logic              access_done;
  logic              wr_cmd;
  logic              wr_sts;
  logic              wr_irq_sts;
  logic              wr_irq_mask;
  logic              addr_known;
  logic [STS_W-1:0]  sts_set;
  logic [STS_W-1:0]  sts_clr;
  logic [STS_W-1:0]  sts_flags;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic [IRQ_W-1:0]  irq_flags;
  logic              nf_msg_now;
  logic              fatal_msg_now;
  logic [31:0]       sts_word;
  logic [31:0]       lane_mask;
  logic [31:0]       cmd_merged;
  logic [31:0]       mask_merged;

  // byte-lane merge shared by the command and mask writes
  function automatic logic [31:0] bcc_lane_merge(input logic [31:0] old_val,
                                                 input logic [31:0] new_val,
                                                 input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction : bcc_lane_merge

  // expands byte strobes so one-to-clear writes respect lanes too
  function automatic logic [31:0] bcc_lane_mask(input logic [3:0] strb);
    return bcc_lane_merge(32'h0000_0000, 32'hffff_ffff, strb);
  endfunction : bcc_lane_mask

  // zero wait state: pready rises in the cycle after setup
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & st_ff.ready;
  assign lane_mask   = bcc_lane_mask(pstrb);

  // lane-merged candidates; cut down to register width where they land
  assign cmd_merged  = bcc_lane_merge({16'h0000, st_ff.cmd}, pwdata, pstrb);
  assign mask_merged = bcc_lane_merge({29'h0000_0000, st_ff.irq_mask}, pwdata, pstrb);

  // address decode, writes land only on the pready edge
  always_comb
  begin
    wr_cmd      = 1'b0;
    wr_sts      = 1'b0;
    wr_irq_sts  = 1'b0;
    wr_irq_mask = 1'b0;
    addr_known  = 1'b1;
    if (paddr == CMD_OFFSET)
      wr_cmd = access_done & pwrite;
    else if (paddr == STS_OFFSET)
      wr_sts = access_done & pwrite;
    else if (paddr == IRQ_STS_OFFSET)
      wr_irq_sts = access_done & pwrite;
    else if (paddr == IRQ_MASK_OFFSET)
      wr_irq_mask = access_done & pwrite;
    else
      addr_known = 1'b0;
  end

  // status word as software sees it
  always_comb
  begin
    sts_word                      = 32'h0000_0000;
    sts_word[STS_PARITY_FLAG_BIT] = sts_flags[0];
    sts_word[STS_SYS_ERR_BIT]     = sts_flags[1];
  end

  // message sends this cycle; own errors need either enable path
  assign nf_msg_now    = (own_err_nonfatal &
                          (st_ff.cmd[SYS_ERR_EN_BIT] | devctl_nonfatal_en)) |
                         (sec_err_nonfatal & st_ff.cmd[SYS_ERR_EN_BIT]);
  assign fatal_msg_now = (own_err_fatal &
                          (st_ff.cmd[SYS_ERR_EN_BIT] | devctl_fatal_en)) |
                         (sec_err_fatal & st_ff.cmd[SYS_ERR_EN_BIT]);

  // status flag events; parity flag locked out while response is off
  always_comb
  begin
    sts_set    = '0;
    sts_set[0] = st_ff.cmd[PARITY_RESP_BIT] &
                 (poisoned_cpl_rx | poisoned_wr_gen);
    sts_set[1] = st_ff.cmd[SYS_ERR_EN_BIT] & (nf_msg_now | fatal_msg_now);
    sts_clr    = '0;
    sts_clr[0] = wr_sts & pwdata[STS_PARITY_FLAG_BIT] &
                 lane_mask[STS_PARITY_FLAG_BIT];
    sts_clr[1] = wr_sts & pwdata[STS_SYS_ERR_BIT] & lane_mask[STS_SYS_ERR_BIT];
  end

  // interrupt events follow the same flag sets plus ur answers
  always_comb
  begin
    irq_set                  = '0;
    irq_set[IRQ_PARITY_BIT]  = sts_set[0];
    irq_set[IRQ_SYS_ERR_BIT] = sts_set[1];
    irq_set[IRQ_UR_BIT]      = up_req_ur;
    irq_clr                  = '0;
    if (wr_irq_sts)
      irq_clr = pwdata[IRQ_W-1:0] & lane_mask[IRQ_W-1:0];
  end

  bcc_flag_bank #(
    .W (STS_W)
  ) u_sts_flags (
    .pclk      (pclk),
    .presetn   (presetn),
    .set_pulse (sts_set),
    .clr_pulse (sts_clr),
    .flags     (sts_flags)
  );

  bcc_flag_bank #(
    .W (IRQ_W)
  ) u_irq_flags (
    .pclk      (pclk),
    .presetn   (presetn),
    .set_pulse (irq_set),
    .clr_pulse (irq_clr),
    .flags     (irq_flags)
  );

  // window claims and upstream gating share the registered command bits
  bcc_req_gate u_req_gate (
    .pclk                   (pclk),
    .presetn                (presetn),
    .io_space_enable        (st_ff.cmd[IO_SPACE_EN_BIT]),
    .memory_space_enable    (st_ff.cmd[MEM_SPACE_EN_BIT]),
    .request_forward_enable (st_ff.cmd[REQ_FWD_EN_BIT]),
    .prim_io_hit            (prim_io_hit),
    .prim_mem_hit           (prim_mem_hit),
    .prim_pref_hit          (prim_pref_hit),
    .up_req_valid           (up_req_valid),
    .up_req_kind            (up_req_kind),
    .up_req_nonposted       (up_req_nonposted),
    .io_claim               (io_claim),
    .mem_claim              (mem_claim),
    .up_req_fwd             (up_req_fwd),
    .up_req_ur              (up_req_ur)
  );

  // next state of bus answer, command bits and side outputs
  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.ready  = setup_phase;
    nxt_st.slverr = setup_phase & ~addr_known;
    nxt_st.rdata  = 32'h0000_0000;
    // read data is prepared during setup so it stands for the access cycle
    if (setup_phase && !pwrite)
    begin
      if (paddr == CMD_OFFSET)
        nxt_st.rdata = {16'h0000, st_ff.cmd & CMD_WR_MASK};
      else if (paddr == STS_OFFSET)
        nxt_st.rdata = sts_word;
      else if (paddr == IRQ_STS_OFFSET)
        nxt_st.rdata = {29'h0000_0000, irq_flags};
      else if (paddr == IRQ_MASK_OFFSET)
        nxt_st.rdata = {29'h0000_0000, st_ff.irq_mask};
      else
        nxt_st.rdata = 32'h0000_0000;
    end
    // writes to fixed-zero bits are dropped by the mask
    if (wr_cmd)
      nxt_st.cmd = cmd_merged[15:0] & CMD_WR_MASK;
    if (wr_irq_mask)
      nxt_st.irq_mask = mask_merged[IRQ_W-1:0];
    nxt_st.own_nf    = nf_msg_now & own_err_nonfatal &
                       (st_ff.cmd[SYS_ERR_EN_BIT] | devctl_nonfatal_en);
    nxt_st.own_fatal = own_err_fatal &
                       (st_ff.cmd[SYS_ERR_EN_BIT] | devctl_fatal_en);
    nxt_st.fwd_cor   = sec_err_cor;
    nxt_st.fwd_nf    = sec_err_nonfatal & st_ff.cmd[SYS_ERR_EN_BIT];
    nxt_st.fwd_fatal = sec_err_fatal & st_ff.cmd[SYS_ERR_EN_BIT];
    // polarity kept as printed: a clear bit negates our own interrupt
    nxt_st.own_int   = own_int_req & st_ff.cmd[LEG_INT_DIS_BIT];
    nxt_st.sec_int   = sec_int_req;
    nxt_st.irq       = |(irq_flags & st_ff.irq_mask);
  end

  // single register stage for all top state; reset clears writable bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff          <= '0;
      st_ff.cmd      <= CMD_RESET;
      st_ff.irq_mask <= IRQ_MASK_RESET;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // every output below is a flip-flop
  assign prdata           = st_ff.rdata;
  assign pready           = st_ff.ready;
  assign pslverr          = st_ff.slverr;
  assign own_nonfatal_msg = st_ff.own_nf;
  assign own_fatal_msg    = st_ff.own_fatal;
  assign fwd_err_cor      = st_ff.fwd_cor;
  assign fwd_err_nonfatal = st_ff.fwd_nf;
  assign fwd_err_fatal    = st_ff.fwd_fatal;
  assign own_int_out      = st_ff.own_int;
  assign sec_int_out      = st_ff.sec_int;
  assign irq              = st_ff.irq;

endmodule : bcc_bridge_cmd

// ===== core/bcc_flag_bank.sv
`timescale 1ns/1ps
module bcc_flag_bank
  import bcc_pkg::*;
#(
  parameter int unsigned W = 2
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set_pulse,
  input  wire logic [W-1:0] clr_pulse,
  output logic      [W-1:0] flags
);

  typedef struct packed
  {
    logic [W-1:0] q;
  } bcc_flag_s;

  bcc_flag_s st_ff;
  bcc_flag_s nxt_st;

  // sticky flags; a set in the clearing cycle wins so no event is lost
  always_comb
  begin
    nxt_st   = st_ff;
    nxt_st.q = (st_ff.q & ~clr_pulse) | set_pulse;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign flags = st_ff.q;

endmodule : bcc_flag_bank

// ===== core/bcc_req_gate.sv
`timescale 1ns/1ps
module bcc_req_gate
  import bcc_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      io_space_enable,
  input  wire logic      memory_space_enable,
  input  wire logic      request_forward_enable,
  input  wire logic      prim_io_hit,
  input  wire logic      prim_mem_hit,
  input  wire logic      prim_pref_hit,
  input  wire logic      up_req_valid,
  input  wire bcc_kind_e up_req_kind,
  input  wire logic      up_req_nonposted,
  output logic           io_claim,
  output logic           mem_claim,
  output logic           up_req_fwd,
  output logic           up_req_ur
);

  typedef struct packed
  {
    logic io_claim;
    logic mem_claim;
    logic fwd;
    logic ur;
  } bcc_gate_s;

  bcc_gate_s st_ff;
  bcc_gate_s nxt_st;
  logic      gated_kind;

  // memory, io and msi requests are the only kinds the forward enable stops
  assign gated_kind = (up_req_kind == KIND_MEM) || (up_req_kind == KIND_IO) ||
                      (up_req_kind == KIND_MSI);

  always_comb
  begin
    nxt_st           = st_ff;
    nxt_st.io_claim  = prim_io_hit & io_space_enable;
    nxt_st.mem_claim = (prim_mem_hit | prim_pref_hit) & memory_space_enable;
    // completions, messages and config pass regardless
    nxt_st.fwd       = up_req_valid & (request_forward_enable | ~gated_kind);
    nxt_st.ur        = up_req_valid & gated_kind & up_req_nonposted &
                       ~request_forward_enable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign io_claim   = st_ff.io_claim;
  assign mem_claim  = st_ff.mem_claim;
  assign up_req_fwd = st_ff.fwd;
  assign up_req_ur  = st_ff.ur;

endmodule : bcc_req_gate

// ===== shared/bcc_pkg.sv
package bcc_pkg;

  // register byte addresses on the apb side
  localparam logic [11:0] CMD_OFFSET      = 12'h004;
  localparam logic [11:0] STS_OFFSET      = 12'h008;
  localparam logic [11:0] IRQ_STS_OFFSET  = 12'h00c;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h010;

  // command register field positions
  localparam int unsigned IO_SPACE_EN_BIT  = 0;
  localparam int unsigned MEM_SPACE_EN_BIT = 1;
  localparam int unsigned REQ_FWD_EN_BIT   = 2;
  localparam int unsigned PARITY_RESP_BIT  = 6;
  localparam int unsigned SYS_ERR_EN_BIT   = 8;
  localparam int unsigned LEG_INT_DIS_BIT  = 10;

  // only bits 0,1,2,6,8,10 hold state; all others read as zero
  localparam logic [15:0] CMD_WR_MASK = 16'h0547;
  localparam logic [15:0] CMD_RESET   = 16'h0000;

  // status register field positions
  localparam int unsigned STS_PARITY_FLAG_BIT = 8;
  localparam int unsigned STS_SYS_ERR_BIT     = 14;
  localparam int unsigned STS_W               = 2;

  // interrupt status and mask layout
  localparam int unsigned IRQ_PARITY_BIT = 0;
  localparam int unsigned IRQ_SYS_ERR_BIT = 1;
  localparam int unsigned IRQ_UR_BIT     = 2;
  localparam int unsigned IRQ_W          = 3;
  localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;

  // kind of request arriving from the secondary side
  typedef enum logic [2:0]
  {
    KIND_MEM = 3'h0,
    KIND_IO  = 3'h1,
    KIND_MSI = 3'h2,
    KIND_MSG = 3'h3,
    KIND_CPL = 3'h4,
    KIND_CFG = 3'h5
  } bcc_kind_e;

endpackage : bcc_pkg

// ===== tb/bcc_asserts.sv
`timescale 1ns/1ps
module bcc_asserts
  import bcc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        prim_io_hit,
  input wire logic        prim_mem_hit,
  input wire logic        prim_pref_hit,
  input wire logic        io_claim,
  input wire logic        mem_claim,
  input wire logic        up_req_valid,
  input wire bcc_kind_e   up_req_kind,
  input wire logic        up_req_nonposted,
  input wire logic        up_req_fwd,
  input wire logic        up_req_ur,
  input wire logic        sec_err_cor,
  input wire logic        sec_err_nonfatal,
  input wire logic        sec_err_fatal,
  input wire logic        fwd_err_cor,
  input wire logic        fwd_err_nonfatal,
  input wire logic        fwd_err_fatal,
  input wire logic        own_int_req,
  input wire logic        own_int_out
);
  logic [15:0] cmd_ff;
  logic [15:0] nxt_cmd;
  logic        blockable;
  logic [1:0]  gated_err;
  // shadow command rebuilt from completed writes, so gating is judged
  // against what software really wrote
  always_comb
  begin
    nxt_cmd = cmd_ff;
    if (psel && penable && pready && pwrite && paddr == CMD_OFFSET)
      nxt_cmd = CMD_WR_MASK & {pstrb[1] ? pwdata[15:8] : cmd_ff[15:8],
                               pstrb[0] ? pwdata[7:0] : cmd_ff[7:0]};
  end
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cmd_ff <= CMD_RESET;
    else
      cmd_ff <= nxt_cmd;
  // request classes and gated error messages
  assign blockable = up_req_kind inside {KIND_MEM, KIND_IO, KIND_MSI};
  assign gated_err = {sec_err_nonfatal, sec_err_fatal} & {2{cmd_ff[SYS_ERR_EN_BIT]}};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  apb_ready_a: assert property (setup_s |=> access_s)
    else $error("apb access not answered");
  io_gate_a: assert property (io_claim == $past(prim_io_hit && cmd_ff[0]))
    else $error("io claim mismatch");
  mem_gate_a: assert property (
    mem_claim == $past((prim_mem_hit || prim_pref_hit) && cmd_ff[1]))
    else $error("memory claim mismatch");
  ur_gate_a: assert property (
    up_req_ur == $past(up_req_valid && up_req_nonposted && blockable && !cmd_ff[2]))
    else $error("unsupported answer mismatch");
  fwd_gate_a: assert property (
    up_req_fwd == $past(up_req_valid && (cmd_ff[2] || !blockable)))
    else $error("upstream forward mismatch");
  err_fwd_a: assert property ({fwd_err_nonfatal, fwd_err_fatal} == $past(gated_err))
    else $error("error message forward mismatch");
  cor_fwd_a: assert property (sec_err_cor |=> fwd_err_cor)
    else $error("correctable message dropped");
  own_int_a: assert property (own_int_out == $past(own_int_req && cmd_ff[10]))
    else $error("own interrupt mismatch");
endmodule : bcc_asserts

// ===== tb/bcc_far_end.sv
`timescale 1ns/1ps
module bcc_far_end
  import bcc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       send_req,
  input  wire logic [2:0] send_kind,
  input  wire logic       send_np,
  input  wire logic [2:0] send_err,
  output bcc_kind_e       up_req_kind,
  output logic            up_req_valid,
  output logic            up_req_nonposted,
  output logic [2:0]      sec_err
);
  // one-cycle pulses; kind and np wander while idle so stale values mean nothing
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      up_req_valid <= 1'b0;
      up_req_kind <= KIND_MEM;
      up_req_nonposted <= 1'b0;
      sec_err <= 3'h0;
    end
    else
    begin
      up_req_valid <= send_req;
      up_req_kind <= send_req ? bcc_kind_e'(send_kind) : bcc_kind_e'(~up_req_kind);
      up_req_nonposted <= send_req ? send_np : ~up_req_nonposted;
      sec_err <= send_err;
    end
endmodule : bcc_far_end

// ===== tb/bridge_command_control_tb_top.sv
`timescale 1ns/1ps
module bridge_command_control_tb_top
  import bcc_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0]  pstrb;
  logic [2:0]  hit, fe_kind, fe_err, sec_err;
  logic [1:0]  poison, own_err, devctl, int_req;
  logic        fe_req, fe_np, up_req_valid, up_req_nonposted;
  bcc_kind_e   up_req_kind;
  wire  [10:0] outs;
  wire         irq;
  int          errors, n_compared, cmd, sts, irqs, mask;

  bcc_bridge_cmd dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prim_io_hit(hit[0]), .prim_mem_hit(hit[1]),
    .prim_pref_hit(hit[2]), .io_claim(outs[10]), .mem_claim(outs[9]),
    .up_req_valid(up_req_valid), .up_req_kind(up_req_kind),
    .up_req_nonposted(up_req_nonposted), .up_req_fwd(outs[8]), .up_req_ur(outs[7]),
    .poisoned_cpl_rx(poison[0]), .poisoned_wr_gen(poison[1]),
    .own_err_nonfatal(own_err[0]), .own_err_fatal(own_err[1]),
    .devctl_nonfatal_en(devctl[0]), .devctl_fatal_en(devctl[1]),
    .own_nonfatal_msg(outs[6]), .own_fatal_msg(outs[5]), .sec_err_cor(sec_err[0]),
    .sec_err_nonfatal(sec_err[1]), .sec_err_fatal(sec_err[2]), .fwd_err_cor(outs[4]),
    .fwd_err_nonfatal(outs[3]), .fwd_err_fatal(outs[2]), .own_int_req(int_req[0]),
    .sec_int_req(int_req[1]), .own_int_out(outs[1]), .sec_int_out(outs[0]), .irq(irq));

  bcc_far_end far (.pclk(pclk), .presetn(presetn), .send_req(fe_req),
    .send_kind(fe_kind), .send_np(fe_np), .send_err(fe_err), .up_req_kind(up_req_kind),
    .up_req_valid(up_req_valid), .up_req_nonposted(up_req_nonposted), .sec_err(sec_err));

  // free-running clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic int lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lanes

  // apb master: ready, read data and error are taken at the rising edge only
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // request holds until the edge at which the slave shows ready
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // write and mirror it in the model
  task automatic wr(input logic [11:0] a, input int d, input logic [3:0] s);
    int m;
    m = lanes(s) & d;
    apb(1'b1, a, d, s);
    if (a == CMD_OFFSET) cmd = (cmd & ~lanes(s)) | (m & CMD_WR_MASK);
    if (a == STS_OFFSET) sts = sts & ~m;
    if (a == IRQ_STS_OFFSET) irqs = irqs & ~m;
    if (a == IRQ_MASK_OFFSET) mask = (mask & ~lanes(s)) | (m & 7);
    chk("write error", !(a inside {CMD_OFFSET, STS_OFFSET, IRQ_STS_OFFSET,
        IRQ_MASK_OFFSET}), err);
  endtask : wr

  task automatic check_regs();
    apb(1'b0, CMD_OFFSET, 0, 4'h0);
    chk("command", cmd, rd);
    chk("read error", 0, err);
    apb(1'b0, STS_OFFSET, 0, 4'h0);
    chk("status", sts, rd);
    apb(1'b0, IRQ_STS_OFFSET, 0, 4'h0);
    chk("irq status", irqs, rd);
    apb(1'b0, IRQ_MASK_OFFSET, 0, 4'h0);
    chk("irq mask", mask, rd);
    chk("irq line", |(irqs & mask), irq);
    apb(1'b0, 12'h014, 0, 4'h0);
    chk("unmapped data", 0, rd);
    chk("unmapped error", 1, err);
  endtask : check_regs

  // one burst of side events from random bits, far end launched an edge early
  task automatic fire(input logic [31:0] v);
    logic [10:0] e;
    int k;
    k = v[15:13] % 6;
    @(posedge pclk);
    fe_req <= v[12];
    fe_kind <= k[2:0];
    fe_np <= v[16];
    fe_err <= v[11:9];
    @(posedge pclk);
    fe_req <= 1'b0;
    fe_err <= 3'h0;
    hit <= v[2:0];
    poison <= v[4:3];
    own_err <= v[6:5];
    devctl <= v[8:7];
    int_req <= v[18:17];
    @(posedge pclk);
    {hit, poison, own_err, int_req} <= '0;
    #1;
    e = {v[0] & cmd[0], (v[1] | v[2]) & cmd[1], v[12] & (cmd[2] | (k > 2)),
         v[12] & v[16] & (k < 3) & !cmd[2], v[5] & (cmd[8] | v[7]),
         v[6] & (cmd[8] | v[8]), v[9], v[10] & cmd[8], v[11] & cmd[8],
         v[17] & cmd[10], v[18]};
    chk("side outputs", e, outs);
    if (cmd[6] && (v[3] || v[4]))
    begin
      sts |= 32'h100;
      irqs |= 1;
    end
    if (cmd[8] && (e[6] | e[5] | e[3] | e[2]))
    begin
      sts |= 32'h4000;
      irqs |= 2;
    end
    if (e[7]) irqs |= 4;
  endtask : fire

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, fe_req, fe_np, paddr, pwdata, pstrb} = '0;
    {hit, poison, own_err, devctl, int_req, fe_kind, fe_err} = '0;
    {errors, n_compared, cmd, sts, irqs, mask} = '0;
    seed = 32'h1f;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check_regs();
    wr(CMD_OFFSET, 32'hffff_ffff, 4'hf);
    wr(12'h014, 32'h0, 4'hf);
    check_regs();
    for (int i = 0; i < 80; i++)
    begin
      seed = lfsr(seed);
      wr(CMD_OFFSET, seed, seed[31:28]);
      seed = lfsr(seed);
      fire(seed);
      seed = lfsr(seed);
      wr(IRQ_MASK_OFFSET, seed, seed[3:0]);
      check_regs();
      seed = lfsr(seed);
      wr(STS_OFFSET, seed, seed[7:4]);
      wr(IRQ_STS_OFFSET, seed, seed[3:0]);
    end
    // second reset after the random loop with state built up
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {cmd, sts, irqs, mask} = '0;
    check_regs();
    tally_and_finish();
  end
endmodule : bridge_command_control_tb_top

bind bcc_bridge_cmd bcc_asserts u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prim_io_hit(prim_io_hit), .prim_mem_hit(prim_mem_hit),
  .prim_pref_hit(prim_pref_hit), .io_claim(io_claim), .mem_claim(mem_claim),
  .up_req_valid(up_req_valid), .up_req_kind(up_req_kind),
  .up_req_nonposted(up_req_nonposted), .up_req_fwd(up_req_fwd), .up_req_ur(up_req_ur),
  .sec_err_cor(sec_err_cor), .sec_err_nonfatal(sec_err_nonfatal),
  .sec_err_fatal(sec_err_fatal), .fwd_err_cor(fwd_err_cor),
  .fwd_err_nonfatal(fwd_err_nonfatal), .fwd_err_fatal(fwd_err_fatal),
  .own_int_req(own_int_req), .own_int_out(own_int_out));
